//--- verilog/cmaski_pkg.sv
// Package: register map, field positions and reset values of the
// acceptance mask and interrupt bookkeeping block.
// Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
package cmaski_pkg;
    localparam int           NUM_BUF        = 15;
    localparam logic [5:0]   OFS_GMASK_HI   = 6'h00;
    localparam logic [5:0]   OFS_GMASK_LO   = 6'h04;
    localparam logic [5:0]   OFS_BMASK_HI   = 6'h08;
    localparam logic [5:0]   OFS_BMASK_LO   = 6'h0C;
    localparam logic [5:0]   OFS_IRQ_EN     = 6'h10;
    localparam logic [5:0]   OFS_IRQ_PEND   = 6'h14;
    localparam logic [5:0]   OFS_IRQ_CLR    = 6'h18;
    localparam logic [5:0]   OFS_CODE_EN    = 6'h1C;
    localparam logic [5:0]   OFS_STATUS     = 6'h20;
    localparam logic [5:0]   OFS_CONFIG     = 6'h24;
    localparam logic [15:0]  RST_REG16      = 16'h0000;
    localparam int           ERR_BIT        = 15;
    localparam int           CFG_ERR_TYPE   = 0;
    localparam int           MH_RTR         = 4;
    localparam int           MH_IDE         = 3;
    localparam int           ML_EXTENDED_REMOTE_MASK_BIT        = 0;
    localparam logic [2:0]   NS_NOT_ACTIVE  = 3'h0;
    localparam logic [4:0]   CODE_NONE      = 5'h00;
    localparam logic [4:0]   CODE_ERROR     = 5'h10;
    localparam int           ST_NS_LSB      = 5;
    localparam int           ST_REQ_BIT     = 4;
endpackage

//--- verilog/cmaski_cmp_if.sv
// Interface: frame and stored identifier handed to the mask comparator.
// Assumes both ends run on the same clock as the top module.
`timescale 1ns/1ps
interface cmaski_cmp_if;
    logic [31:0] mask;      // Mask in hi:lo register layout
    logic [28:0] rx_id;     // Received identifier
    logic        rx_ide;    // Received IDE
    logic        rx_rtr;    // Received RTR
    logic        rx_srr;    // Received SRR
    logic [28:0] buf_id;    // Stored identifier
    logic        buf_ide;   // Stored IDE
    logic        buf_rtr;   // Stored RTR
    logic        buf_srr;   // Stored SRR
    logic        match;     // Frame accepted
    logic [28:0] new_id;    // Stored identifier after merge
    logic        new_rtr;   // Stored RTR after merge
    logic        new_srr;   // Stored SRR after merge
    modport top (output mask, rx_id, rx_ide, rx_rtr, rx_srr, buf_id, buf_ide,
                 buf_rtr, buf_srr, input match, new_id, new_rtr, new_srr);
    modport cmp (input mask, rx_id, rx_ide, rx_rtr, rx_srr, buf_id, buf_ide,
                 buf_rtr, buf_srr, output match, new_id, new_rtr, new_srr);
endinterface

//--- verilog/cmaski_match.sv
// Mask comparator: applies one 32-bit mask to a received frame.
// Assumes the mask arrives in the high:low register layout.
`timescale 1ns/1ps
module cmaski_match
    import cmaski_pkg::*;
(
    cmaski_cmp_if.cmp c     // Comparison operands and result
);
    wire [28:0] id_dc    = {c.mask[31:21], c.mask[18:16], c.mask[15:1]};
    wire        rtr_dc   = c.mask[16 + MH_RTR];
    wire        ide_dc   = c.mask[16 + MH_IDE];
    wire        extended_remote_mask_bit_dc  = c.mask[ML_EXTENDED_REMOTE_MASK_BIT];
    wire [28:0] id_diff  = (c.rx_id ^ c.buf_id) & ~id_dc;
    // Standard frames keep their 11-bit id in bits 28..18
    wire        std_ok   = (id_diff[28:18] == 11'h000)
                           && (rtr_dc || c.rx_rtr == c.buf_rtr);
    wire        ext_ok   = (id_diff == 29'h00000000)
                           && (rtr_dc || c.rx_srr == c.buf_srr)
                           && (extended_remote_mask_bit_dc || c.rx_rtr == c.buf_rtr);
    wire        ide_ok   = ide_dc || (c.rx_ide == c.buf_ide);
    wire [28:0] std_dc   = {id_dc[28:18], 18'h00000};
    wire [28:0] use_dc   = c.rx_ide ? id_dc : std_dc;
    wire        rtr_sel  = c.rx_ide ? extended_remote_mask_bit_dc : rtr_dc;

    assign c.match   = ide_ok && (c.rx_ide ? ext_ok : std_ok);
    // Don't-care bits take the received value on acceptance; standard frames merge only bits 28..18
    assign c.new_id  = (c.buf_id & ~use_dc) | (c.rx_id & use_dc);
    assign c.new_rtr = rtr_sel ? c.rx_rtr : c.buf_rtr;
    assign c.new_srr = (c.rx_ide && rtr_dc) ? c.rx_srr : c.buf_srr;
endmodule

//--- verilog/cmaski_top.sv
// Acceptance masks, interrupt pending/enable/code and node status.
// Assumes an Avalon-MM master and a protocol engine on the same clock.
`timescale 1ns/1ps
module cmaski_top
    import cmaski_pkg::*;
(
    input  wire logic        i_clock,             // 200 MHz clock
    input  wire logic        i_sys_rst,           // Async reset, high
    input  wire logic [5:0]  i_avs_address,       // Byte address
    input  wire logic        i_avs_read,          // Read request
    input  wire logic        i_avs_write,         // Write request
    input  wire logic [31:0] i_avs_writedata,     // Write data
    input  wire logic [3:0]  i_avs_byteenable,    // Byte lanes
    output logic      [31:0] o_avs_readdata,      // Read data
    output logic             o_avs_waitrequest,   // Stall
    input  wire logic        i_rx_check,          // Compare request
    input  wire logic        i_rx_use_buf14,      // Apply buffer 14 mask
    input  wire logic [28:0] i_rx_id,             // Received identifier
    input  wire logic        i_rx_ide,            // Received IDE
    input  wire logic        i_rx_rtr,            // Received RTR
    input  wire logic        i_rx_srr,            // Received SRR
    input  wire logic [28:0] i_buf_id,            // Stored identifier
    input  wire logic        i_buf_ide,           // Stored IDE
    input  wire logic        i_buf_rtr,           // Stored RTR
    input  wire logic        i_buf_srr,           // Stored SRR
    output logic             o_rx_accept,         // Frame accepted
    output logic      [28:0] o_new_id,            // Id to store back
    output logic             o_new_rtr,           // RTR to store back
    output logic             o_new_srr,           // SRR to store back
    input  wire logic [14:0] i_buf_done,          // Transfer done pulses
    input  wire logic        i_bus_error,         // Bus error pulse
    input  wire logic        i_cnt_incr,          // Error counter bumped
    input  wire logic [2:0]  i_node_state,        // Engine node state
    output logic             o_irq                // Interrupt request
);
    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [15:0] gmask_hi, gmask_lo, bmask_hi, bmask_lo;
    logic [15:0] irq_enable, irq_pending, irq_code_enable, config_reg;
    logic [2:0]  ns_s1, node_state;
    logic        ack;
    logic [31:0] rdata;
    logic [2:0]  ns_prev;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus decode: one wait cycle, answer on second cycle
    wire         req        = i_avs_read | i_avs_write;
    wire         wr_take    = i_avs_write & ack;
    wire         sel_gh     = i_avs_address == OFS_GMASK_HI;
    wire         sel_gl     = i_avs_address == OFS_GMASK_LO;
    wire         sel_bh     = i_avs_address == OFS_BMASK_HI;
    wire         sel_bl     = i_avs_address == OFS_BMASK_LO;
    wire         sel_en     = i_avs_address == OFS_IRQ_EN;
    wire         sel_pd     = i_avs_address == OFS_IRQ_PEND;
    wire         sel_clr    = i_avs_address == OFS_IRQ_CLR;
    wire         sel_ce     = i_avs_address == OFS_CODE_EN;
    wire         sel_st     = i_avs_address == OFS_STATUS;
    wire         sel_cfg    = i_avs_address == OFS_CONFIG;
    wire [15:0]  clr_bits   = (wr_take && sel_clr) ?
                              merge16(RST_REG16, i_avs_writedata, i_avs_byteenable)
                              : RST_REG16;
    wire [15:0]  status_word;
    wire [15:0]  rd_mux     = sel_gh  ? gmask_hi :
                              sel_gl  ? gmask_lo :
                              sel_bh  ? bmask_hi :
                              sel_bl  ? bmask_lo :
                              sel_en  ? irq_enable :
                              sel_pd  ? irq_pending :
                              sel_ce  ? irq_code_enable :
                              sel_st  ? status_word :
                              sel_cfg ? config_reg : RST_REG16;

    assign o_avs_waitrequest = req & ~ack;
    assign o_avs_readdata    = rdata;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ack   <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ack   <= req & ~ack;
            rdata <= {16'h0000, rd_mux};
        end
    end

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gmask_hi        <= RST_REG16;
            gmask_lo        <= RST_REG16;
            bmask_hi        <= RST_REG16;
            bmask_lo        <= RST_REG16;
            irq_enable      <= RST_REG16;
            irq_code_enable <= RST_REG16;
            config_reg      <= RST_REG16;
        end else if (wr_take) begin
            // Two halves kept apart, joined only at the comparator
            if (sel_gh)  gmask_hi <= merge16(gmask_hi, i_avs_writedata, i_avs_byteenable);
            if (sel_gl)  gmask_lo <= merge16(gmask_lo, i_avs_writedata, i_avs_byteenable);
            if (sel_bh)  bmask_hi <= merge16(bmask_hi, i_avs_writedata, i_avs_byteenable);
            if (sel_bl)  bmask_lo <= merge16(bmask_lo, i_avs_writedata, i_avs_byteenable);
            if (sel_en)  irq_enable <= merge16(irq_enable, i_avs_writedata, i_avs_byteenable);
            if (sel_ce)  irq_code_enable <= merge16(irq_code_enable, i_avs_writedata,
                                                    i_avs_byteenable);
            if (sel_cfg) config_reg <= {15'h0000, be_cfg_bit(config_reg[CFG_ERR_TYPE])};
        end
    end

    function automatic logic be_cfg_bit(input logic old);
        be_cfg_bit = i_avs_byteenable[0] ? i_avs_writedata[CFG_ERR_TYPE] : old;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Acceptance compare
    cmaski_cmp_if cmp_bus ();
    assign cmp_bus.mask    = i_rx_use_buf14 ? {bmask_hi, bmask_lo}
                                            : {gmask_hi, gmask_lo};
    assign cmp_bus.rx_id   = i_rx_id;
    assign cmp_bus.rx_ide  = i_rx_ide;
    assign cmp_bus.rx_rtr  = i_rx_rtr;
    assign cmp_bus.rx_srr  = i_rx_srr;
    assign cmp_bus.buf_id  = i_buf_id;
    assign cmp_bus.buf_ide = i_buf_ide;
    assign cmp_bus.buf_rtr = i_buf_rtr;
    assign cmp_bus.buf_srr = i_buf_srr;

    cmaski_match u_match (
        .c (cmp_bus.cmp)
    );

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_rx_accept <= 1'b0;
            o_new_id    <= 29'h00000000;
            o_new_rtr   <= 1'b0;
            o_new_srr   <= 1'b0;
        end else begin
            o_rx_accept <= i_rx_check & cmp_bus.match;
            o_new_id    <= cmp_bus.new_id;
            o_new_rtr   <= cmp_bus.new_rtr;
            o_new_srr   <= cmp_bus.new_srr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Node state and error events
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ns_s1      <= NS_NOT_ACTIVE;
            node_state <= NS_NOT_ACTIVE;
            ns_prev    <= NS_NOT_ACTIVE;
        end else begin
            ns_s1      <= i_node_state;
            node_state <= ns_s1;
            ns_prev    <= node_state;
        end
    end

    // Passive and bus-off ignore the low code bit
    wire [2:0] ns_key   = node_state[2] ? {node_state[2:1], 1'b0} : node_state;
    wire [2:0] prev_key = ns_prev[2] ? {ns_prev[2:1], 1'b0} : ns_prev;
    wire       ns_change = ns_key != prev_key;
    // Counter bump and the resulting state can land a cycle apart
    logic      incr_seen;
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) incr_seen <= 1'b0;
        else           incr_seen <= i_cnt_incr | (incr_seen & ~ns_change);
    end
    wire       err_event = config_reg[CFG_ERR_TYPE]
                           ? (ns_change & (incr_seen | i_cnt_incr))
                           : i_bus_error;

    ////////////////////////////////////////////////////////////////////
    // Pending flags: a set in the same cycle as a clear wins
    wire [15:0] set_bits     = {err_event, i_buf_done};
    wire [15:0] next_pending = (irq_pending & ~clr_bits) | set_bits;

    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) irq_pending <= RST_REG16;
        else           irq_pending <= next_pending;
    end

    // Error bit 15, buffers 14..0
    assign o_irq = |(irq_pending & irq_enable);

    ////////////////////////////////////////////////////////////////////
    // Interrupt code, error first then lowest buffer
    wire [15:0] code_src = irq_pending & irq_code_enable;

    function automatic logic [4:0] pick_code(input logic [15:0] src);
        pick_code = CODE_NONE;
        for (int n = NUM_BUF - 1; n >= 0; n--) begin
            if (src[n]) pick_code = {1'b1, 4'(n + 1)};
        end
        if (src[ERR_BIT]) pick_code = CODE_ERROR;
    endfunction

    wire [4:0] irq_code = pick_code(code_src);
    assign status_word = {8'h00, node_state, irq_code};

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_clr_err;
        @(posedge i_clock) disable iff (i_sys_rst)
        (clr_bits[ERR_BIT] && !err_event) |=> !irq_pending[ERR_BIT];
    endproperty
    a_clr_err: assert property (p_clr_err) else $error("error pending not cleared");

    property p_set_wins;
        @(posedge i_clock) disable iff (i_sys_rst)
        (i_buf_done[0] && clr_bits[0]) |=> irq_pending[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_set_buf;
        @(posedge i_clock) disable iff (i_sys_rst)
        i_buf_done[14] |=> irq_pending[14];
    endproperty
    a_set_buf: assert property (p_set_buf) else $error("buffer pending not set");

    property p_err_hold;
        @(posedge i_clock) disable iff (i_sys_rst)
        (irq_pending[ERR_BIT] && !clr_bits[ERR_BIT]) |=> irq_pending[ERR_BIT];
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error pending dropped");

    property p_code_err;
        @(posedge i_clock) disable iff (i_sys_rst)
        code_src[ERR_BIT] |-> status_word[4:0] == CODE_ERROR;
    endproperty
    a_code_err: assert property (p_code_err) else $error("error code wrong");

    property p_code_b0;
        @(posedge i_clock) disable iff (i_sys_rst)
        (code_src[ERR_BIT:0] == 16'h0001) |-> status_word[4:0] == 5'h11;
    endproperty
    a_code_b0: assert property (p_code_b0) else $error("buffer 0 code wrong");

    property p_code_masked;
        @(posedge i_clock) disable iff (i_sys_rst)
        (irq_code_enable == 16'h0000) |-> status_word[ST_REQ_BIT] == 1'b0;
    endproperty
    a_code_masked: assert property (p_code_masked) else $error("code shown while disabled");

    property p_irq_gate;
        @(posedge i_clock) disable iff (i_sys_rst)
        (irq_enable[ERR_BIT] == 1'b0 && irq_enable[14:0] == 15'h0000) |-> !o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq with all disabled");

    property p_ns_pass;
        @(posedge i_clock) disable iff (i_sys_rst)
        1'b1 |-> ##2 status_word[7:ST_NS_LSB] == $past(i_node_state, 2);
    endproperty
    a_ns_pass: assert property (p_ns_pass) else $error("node state wrong");
endmodule

//--- test/cmaski_engine_model.sv
// Engine-side model: frames to compare, transfer and error pulses, node state.
// Assumes one shared clock; the bench calls its tasks one at a time.
`timescale 1ns/1ps
module cmaski_engine_model (
    input  wire logic        i_clock,      // Shared clock
    output logic             o_check,      // Compare request
    output logic             o_use_buf14,  // Select buffer 14 mask
    output logic      [28:0] o_rx_id,      // Received id
    output logic      [2:0]  o_rx_flags,   // Received ide, rtr, srr
    output logic      [28:0] o_buf_id,     // Stored id
    output logic      [2:0]  o_buf_flags,  // Stored ide, rtr, srr
    output logic      [14:0] o_done,       // Transfer done pulses
    output logic             o_bus_error,  // Bus error pulse
    output logic             o_cnt_incr,   // Error counter bumped
    output logic      [2:0]  o_node_state  // Node state level
);
    initial begin
        {o_check, o_use_buf14, o_rx_id, o_rx_flags, o_buf_id, o_buf_flags} = '0;
        {o_done, o_bus_error, o_cnt_incr, o_node_state} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic frame(input logic b14, input logic [28:0] ri, input logic [2:0] rf,
                         input logic [28:0] bi, input logic [2:0] bf);
        @(posedge i_clock);
        o_check     <= 1'b1;
        o_use_buf14 <= b14;
        o_rx_id     <= ri;
        o_rx_flags  <= rf;
        o_buf_id    <= bi;
        o_buf_flags <= bf;
        @(posedge i_clock);
        // Released lines must not keep showing the old frame
        o_check     <= 1'b0;
        o_rx_id     <= ~ri;
        o_rx_flags  <= ~rf;
        o_buf_id    <= ~bi;
        o_buf_flags <= ~bf;
    endtask
    task automatic events(input logic [14:0] d, input logic be, input logic ci);
        @(posedge i_clock);
        o_done      <= d;
        o_bus_error <= be;
        o_cnt_incr  <= ci;
        @(posedge i_clock);
        o_done      <= 15'h0000;
        o_bus_error <= 1'b0;
        o_cnt_incr  <= 1'b0;
    endtask
    task automatic state(input logic [2:0] s);
        @(posedge i_clock);
        o_node_state <= s;
    endtask
endmodule

//--- test/tb.sv
// Self-checking bench: register bus, mask compare and interrupt bookkeeping.
// Assumes the engine model drives every engine-side input of the block.
`timescale 1ns/1ps
`define CHK(n, e, g) tests_run++; \
    if ((g) !== (e)) begin \
        $display("unexpected %s exp %h got %h", n, e, g); \
        err_count++; \
    end
module tb;
    import cmaski_pkg::*;
    logic        i_clock, i_sys_rst, rd, wr, rx_check, use14, bus_err, cnt_inc;
    logic        acc, new_rtr, new_srr, o_irq, o_avs_waitrequest, b14;
    logic [5:0]  addr;
    logic [31:0] wdata, o_avs_readdata, flip, exp_r;
    logic [28:0] rx_id, buf_id, new_id, rid, bid;
    logic [2:0]  rx_f, buf_f, node_st, rf, bf;
    logic [14:0] done;
    logic [15:0] m[4];
    logic [15:0] ev, cen, en, clr, pend;
    logic [2:0]  ns_tab[5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
    int          seed = 9979;
    int          err_count = 0;
    int          tests_run = 0;
    cmaski_engine_model eng (.i_clock(i_clock), .o_check(rx_check), .o_use_buf14(use14),
        .o_rx_id(rx_id), .o_rx_flags(rx_f), .o_buf_id(buf_id), .o_buf_flags(buf_f),
        .o_done(done), .o_bus_error(bus_err), .o_cnt_incr(cnt_inc), .o_node_state(node_st));
    cmaski_top DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_rx_check(rx_check), .i_rx_use_buf14(use14), .i_rx_id(rx_id), .i_rx_ide(rx_f[2]),
        .i_rx_rtr(rx_f[1]), .i_rx_srr(rx_f[0]), .i_buf_id(buf_id), .i_buf_ide(buf_f[2]),
        .i_buf_rtr(buf_f[1]), .i_buf_srr(buf_f[0]), .o_rx_accept(acc), .o_new_id(new_id),
        .o_new_rtr(new_rtr), .o_new_srr(new_srr), .i_buf_done(done), .i_bus_error(bus_err),
        .i_cnt_incr(cnt_inc), .i_node_state(node_st), .o_irq(o_irq));
    initial i_clock = 1'b0;
    always #2.5 i_clock = ~i_clock;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] frame_res(input logic [31:0] mk, input logic [28:0] ri,
            input logic [2:0] f, input logic [28:0] bi, input logic [2:0] g);
        logic [28:0] dc;
        logic [28:0] cdc;
        logic        rm;
        logic        ok;
        dc  = {mk[31:21], mk[18:16], mk[15:1]};
        // Standard frames: low id bits neither compared nor merged
        cdc = f[2] ? dc : {dc[28:18], 18'h3FFFF};
        dc  = f[2] ? dc : {dc[28:18], 18'h00000};
        rm  = f[2] ? mk[0] : mk[20];
        ok  = (((ri ^ bi) & ~cdc) == 29'h0) && (mk[19] || f[2] == g[2]);
        ok  = ok && (rm || f[1] == g[1]) && (!f[2] || mk[20] || f[0] == g[0]);
        return {ok, (ri & dc) | (bi & ~dc), rm ? f[1] : g[1], (f[2] && mk[20]) ? f[0] : g[0]};
    endfunction
    function automatic logic [4:0] exp_code(input logic [15:0] p, input logic [15:0] c);
        logic [15:0] a;
        a = p & c;
        if (a[15]) return 5'h10;
        for (int n = 0; n < 15; n++) if (a[n]) return {1'b1, 4'(n + 1)};
        return 5'h00;
    endfunction
    task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d,
                       output logic [31:0] q);
        @(posedge i_clock);
        addr  <= a;
        wdata <= {16'h0000, d};
        rd    <= ~w;
        wr    <= w;
        @(posedge i_clock iff o_avs_waitrequest === 1'b0);
        q = o_avs_readdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wr16(input logic [5:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdchk(input string n, input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        `CHK(n, e, q)
    endtask
    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
    initial begin
        {i_sys_rst, rd, wr, addr, wdata, pend} = {1'b1, 56'h0};
        repeat (8) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        for (int k = 0; k < 16; k++) rdchk("reset", 6'(k * 4), 32'h0);
        for (int k = 0; k < 4; k++) begin
            m[k] = 16'($random(seed));
            wr16(6'(k * 4), m[k]);
            rdchk("mask", 6'(k * 4), {16'h0000, m[k]});
        end
        for (int k = 0; k < 80; k++) begin
            b14  = 1'($random(seed));
            rid  = 29'($random(seed));
            rf   = 3'($random(seed));
            // Every fourth frame identical so acceptance is reached often
            flip = (k % 4 == 0) ? 32'h0 : $random(seed) & $random(seed) & $random(seed);
            bid  = rid ^ flip[28:0];
            bf   = rf ^ flip[31:29];
            exp_r = frame_res(b14 ? {m[2], m[3]} : {m[0], m[1]}, rid, rf, bid, bf);
            eng.frame(b14, rid, rf, bid, bf);
            #1;
            `CHK("accept", exp_r[31], acc)
            `CHK("new_id", exp_r[30:2], new_id)
            `CHK("new_rtr", exp_r[1], new_rtr)
            `CHK("new_srr", exp_r[0], new_srr)
        end
        wr16(OFS_CODE_EN, 16'hFFFF);
        for (int k = 0; k < 15; k++) begin
            eng.events(15'(1 << k), 1'b0, 1'b0);
            rdchk("pend", OFS_IRQ_PEND, 32'(1 << k));
            rdchk("code", OFS_STATUS, {27'h0, 1'b1, 4'(k + 1)});
            wr16(OFS_IRQ_CLR, 16'(1 << k));
        end
        for (int k = 0; k < 24; k++) begin
            {ev, cen} = $random(seed);
            {en, clr} = $random(seed);
            if (k == 0) ev = 16'hFFFF;
            if (k == 1) clr = 16'h0000;
            wr16(OFS_CODE_EN, cen);
            wr16(OFS_IRQ_EN, en);
            eng.events(ev[14:0], ev[15], 1'b0);
            pend = pend | ev;
            #1;
            `CHK("irq", |(pend & en), o_irq)
            rdchk("pend", OFS_IRQ_PEND, {16'h0000, pend});
            rdchk("code", OFS_STATUS, {27'h0, exp_code(pend, cen)});
            wr16(OFS_IRQ_PEND, 16'h0000);
            wr16(OFS_IRQ_CLR, clr);
            pend = pend & ~clr;
            rdchk("clear", OFS_IRQ_PEND, {16'h0000, pend});
        end
        wr16(OFS_CODE_EN, 16'h0000);
        foreach (ns_tab[i]) begin
            eng.state(ns_tab[i]);
            repeat (3) @(posedge i_clock);
            rdchk("state", OFS_STATUS, {24'h0, ns_tab[i], 5'h00});
        end
        wr16(OFS_CONFIG, 16'h0001);
        wr16(OFS_IRQ_CLR, 16'hFFFF);
        eng.events(15'h0000, 1'b1, 1'b0);
        rdchk("err_type", OFS_IRQ_PEND, 32'h0);
        eng.state(3'h7);
        eng.events(15'h0000, 1'b0, 1'b1);
        repeat (4) @(posedge i_clock);
        rdchk("err_type", OFS_IRQ_PEND, 32'h0);
        eng.state(3'h4);
        eng.events(15'h0000, 1'b0, 1'b1);
        repeat (4) @(posedge i_clock);
        rdchk("err_type", OFS_IRQ_PEND, 32'h8000);
        wr16(OFS_IRQ_CLR, 16'h7FFF);
        rdchk("err_hold", OFS_IRQ_PEND, 32'h8000);
        wr16(OFS_IRQ_CLR, 16'h8000);
        rdchk("err_clear", OFS_IRQ_PEND, 32'h0);
        // Class change with no counter bump since the last change
        eng.state(3'h2);
        repeat (4) @(posedge i_clock);
        rdchk("err_type", OFS_IRQ_PEND, 32'h0);
        // Clear write lands on the edge that samples the done pulse
        fork
            wr16(OFS_IRQ_CLR, 16'h0001);
            begin
                @(posedge i_clock);
                eng.events(15'h0001, 1'b0, 1'b0);
            end
        join
        rdchk("set_wins", OFS_IRQ_PEND, 32'h1);
        wr16(OFS_IRQ_CLR, 16'h0001);
        rdchk("set_clear", OFS_IRQ_PEND, 32'h0);
        give_verdict();
    end
endmodule
